// >>> hw/t1fs_cand_mem.sv
// Purpose: Per-bit-position candidate history store for the frame hunt
// Assumes: One read and one write port, distinct addresses in the same cycle
// Notes: Read data is registered; contents are undefined until first written
`timescale 1ns/1ps
module t1fs_cand_mem #(
  parameter int W     = 29,
  parameter int DEPTH = 193,
  parameter int AW    = 8
) (
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic          re_i,
  input  wire logic [AW-1:0] raddr_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [W-1:0]  wdata_i,
  output logic      [W-1:0]  rdata_o
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
    end else if (ce_i && re_i) begin
      rdata_o <= mem[raddr_i];
    end
  end

endmodule : t1fs_cand_mem

// >>> hw/t1fs_pkg.sv
// Purpose: Shared constants and types of the T1/J1 receive frame synchronizer
// Assumes: 100 MHz clk_i, line bits delivered one per strobe by on-chip recovery logic
// Notes: Registers are 32-bit words on a classic Wishbone slave
//
// Notes on behaviour
// R1 - Framer runs only while the line standard select bit is one.
// R2 - Frame is 193 bits at 8 kHz: framing bit plus 24 slots of 8.
// R3 - Two-bit format select picks F4, F12, ESF or F72 multiframe.
// R4 - Frame alignment lost flag shows sync status to software.
// R5 - Each terminal or multiframe framing bit error bumps the error counter; the code skips multiframe bit errors during a split-mode multiframe hunt.
// R6 - Error counting pauses while automatic resync is enabled.
// R7 - Loss criterion: 2 in 4, 2 in 5, 2 in 6, or 4 bad ESF multiframes.
// R8 - Auto mode resyncs on loss; force and external loss still accepted.
// R9 - Non-auto mode resyncs only on force or external loss bit.
// R10 - F12/F72 split mode: multiframe errors restart only multiframe alignment.
// R11 - In sync, force or external loss restarts search; one definite candidate needed.
// R12 - Async: external loss restarts; force locks next candidate or restarts search.
// R13 - Software should use external loss first, force only if still async.
// R14 - Search restart flag toggles when a new search follows a fruitless one.
// R15 - Resync ends within 1.5, 4.5, 6.125 or 17.75 ms per format.
// R16 - F4 terminal bit is 1 in frame 1, 0 in frame 3.
// R17 - F4 remote alarm is bit 2 low in every time slot.
// R18 - F4 multiframe sync comes from terminal framing bits alone.
// R19 - F12 terminal bits alternate 1,0; multiframe bits read 0,0,1,1,1,0.
// R20 - F12 alarm select: 0 means bit-2 alarm, 1 means frame-12 bit 0-to-1.
// R21 - Combined mode raises multiframe lost too; regain after two good multiframes.
// R22 - Frame alignment lost stays high through async state, clears on sync.
package t1fs_pkg;

  // Line frame geometry
  localparam int          FRAME_BITS    = 193;
  localparam int          TS_PER_FRAME  = 24;
  localparam int          BITS_PER_TS   = 8;
  localparam int          FRAME_RATE_HZ = 8000;
  localparam logic [7:0]  LAST_BIT_POS  = 8'(FRAME_BITS - 1);
  localparam logic [2:0]  ALARM_SLOT_BIT = 3'h1;  // Zero-based index 1, which is slot bit 2

  // Register map (byte addresses)
  localparam int          WB_ADR_W  = 8;
  localparam logic [7:0]  ADR_CTRL  = 8'h00;
  localparam logic [7:0]  ADR_CMD   = 8'h04;
  localparam logic [7:0]  ADR_STAT  = 8'h08;
  localparam logic [7:0]  ADR_FEC   = 8'h0c;
  localparam logic [7:0]  CTRL_RST  = 8'h00;
  localparam int          CMD_FRC   = 0;
  localparam int          CMD_EXL   = 1;

  typedef enum logic [1:0] {
    FMT_F4  = 2'b00,
    FMT_F12 = 2'b01,
    FMT_ESF = 2'b10,
    FMT_F72 = 2'b11
  } t1fs_fmt_t;

  typedef enum logic [1:0] {
    CRIT_2OF4 = 2'b00,
    CRIT_2OF5 = 2'b01,
    CRIT_2OF6 = 2'b10,
    CRIT_ESF4 = 2'b11
  } t1fs_crit_t;

  typedef enum logic [1:0] {
    ST_OFF    = 2'b00,
    ST_LOST   = 2'b01,
    ST_SEARCH = 2'b10,
    ST_SYNC   = 2'b11
  } t1fs_state_t;

  // Control word, bit 0 first: lstd, fmt[2:1], crit[4:3], auto 5, split 6, alarm 7
  typedef struct packed {
    logic       alarm_method_select;
    logic       split_sync_select;
    logic       auto_resync_enable;
    t1fs_crit_t sync_loss_criterion;
    t1fs_fmt_t  framing_format_select;
    logic       line_standard_select;
  } t1fs_ctl_t;

  // Status word, bit 0 first: lfa, lmfa, fsrf, remote alarm, state[5:4]
  typedef struct packed {
    t1fs_state_t st;
    logic        remote_alarm;
    logic        search_restart_flag;
    logic        multiframe_alignment_lost_flag;
    logic        frame_alignment_lost_flag;
  } t1fs_stat_t;

  // Multiframe lengths in frames
  localparam logic [6:0]  MF_LEN_F4  = 7'h04;
  localparam logic [6:0]  MF_LEN_F12 = 7'h0c;
  localparam logic [6:0]  MF_LEN_ESF = 7'h18;
  localparam logic [6:0]  MF_LEN_F72 = 7'h48;

  // Frames of history a candidate must match
  localparam logic [4:0]  HUNT_WIN_F4  = 5'h08;
  localparam logic [4:0]  HUNT_WIN_F12 = 5'h0c;
  localparam logic [4:0]  HUNT_WIN_ESF = 5'h18;
  localparam int          HIST_W       = 24;

  // Framing patterns, indexed by framing-bit ordinal within the multiframe
  localparam logic [5:0]  F12_FS_PAT   = 6'h1c;  // Frames 2..12: 0,0,1,1,1,0
  localparam logic [5:0]  ESF_FAS_PAT  = 6'h34;  // Frames 4..24: 0,0,1,0,1,1
  localparam logic [5:0]  F12_FS_HUNT  = 6'h0e;  // Same, newest bit in bit 0

  // Loss and regain thresholds
  localparam int          LOSS_ERRS     = 2;
  localparam int          LOSS_WIN_MIN  = 4;
  localparam logic [2:0]  ESF_BAD_MF_MAX = 3'h4;
  localparam logic [1:0]  MF_GOOD_NEED   = 2'h2;

  // Longest resync times, and the search period in frames derived from them
  localparam real         F4_RESYNC_MAX_MS  = 1.5;
  localparam real         F12_RESYNC_MAX_MS = 4.5;
  localparam real         ESF_RESYNC_MAX_MS = 6.125;
  localparam real         F72_RESYNC_MAX_MS = 17.75;
  localparam real         FRAMES_PER_MS     = FRAME_RATE_HZ / 1000.0;
  localparam logic [7:0]  PER_F4  = 8'(int'($floor(F4_RESYNC_MAX_MS * FRAMES_PER_MS)));
  localparam logic [7:0]  PER_F12 = 8'(int'($floor(F12_RESYNC_MAX_MS * FRAMES_PER_MS)));
  localparam logic [7:0]  PER_ESF = 8'(int'($floor(ESF_RESYNC_MAX_MS * FRAMES_PER_MS)));
  localparam logic [7:0]  PER_F72 = 8'(int'($floor(F72_RESYNC_MAX_MS * FRAMES_PER_MS)));

endpackage : t1fs_pkg

// >>> hw/t1fs_sync.sv
// Purpose: T1/J1 receive frame synchronizer with Wishbone control and status
// Assumes: rx_bit_en_i strobes at most every third clock, same clock domain
// Notes: Hunt checks all 193 positions in turn, one per line bit, through the history store
`timescale 1ns/1ps
module t1fs_sync
  import t1fs_pkg::*;
#(
  parameter int FEC_W = 16
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                ce_i,
  input  wire logic                rx_bit_i,
  input  wire logic                rx_bit_en_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [WB_ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  output logic                     frame_alignment_lost_o,
  output logic                     multiframe_alignment_lost_o
);

  localparam int FILL_W = 5;
  localparam int MEM_W  = HIST_W + FILL_W;

  typedef struct packed {
    t1fs_ctl_t        ctl;
    logic             frc_p;
    logic             exl_p;
    t1fs_state_t      st;
    logic             lfa;
    logic             lmfa;
    logic             fsrf;
    logic             ralm;
    logic [FEC_W-1:0] fec;
    logic             ack;
    logic [31:0]      dat;
    logic [7:0]       bit_pos;
    logic             s1_v;
    logic             s1_bit;
    logic [7:0]       s1_pos;
    logic             wt;
    logic [7:0]       sf;
    logic [1:0]       ncand;
    logic [7:0]       cand_pos;
    logic [6:0]       cand_fr;
    logic [7:0]       f_pos;
    logic [6:0]       frame_cnt;
    logic [5:0]       ft_h;
    logic [5:0]       fs_h;
    logic [2:0]       bad_mf;
    logic             mf_err;
    logic [1:0]       mf_good;
    logic             mf_hunt;
    logic             mf_seen;
    logic [5:0]       fs_sh;
    logic             b2_zero;
    logic             ra_b2;
    logic             ra_fs;
  } t1fs_regs_t;

  t1fs_regs_t s;
  t1fs_regs_t n;

  logic              mwe;
  logic [MEM_W-1:0]  mwdata;
  logic [MEM_W-1:0]  mrdata;

  t1fs_cand_mem #(.W(MEM_W), .DEPTH(FRAME_BITS), .AW(8)) u_mem (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .re_i    (rx_bit_en_i),
    .raddr_i (s.bit_pos),
    .we_i    (mwe),
    .waddr_i (s.s1_pos),
    .wdata_i (mwdata),
    .rdata_o (mrdata)
  );

  // Expected framing bit of frame idx: {terminal, multiframe, value}
  function automatic logic [2:0] exp_bit(input t1fs_fmt_t f, input logic [6:0] idx);
    logic [6:0] i12;
    i12 = idx % MF_LEN_F12;
    exp_bit = 3'h0;
    case (f)
      FMT_F4: begin
        if (idx == 7'h00) exp_bit = 3'h5;                 // see R16
        else if (idx == 7'h02) exp_bit = 3'h4;            // see R16
      end
      FMT_ESF: begin
        if (idx[1:0] == 2'h3) exp_bit = {2'b10, ESF_FAS_PAT[idx[4:2]]};
      end
      default: begin
        if (!i12[0]) exp_bit = {2'b10, ~i12[1]};          // see R19
        else exp_bit = {2'b01, F12_FS_PAT[i12[3:1]]};     // see R19
      end
    endcase
  endfunction : exp_bit

  function automatic logic win_loss(input logic [5:0] h, input t1fs_crit_t c);
    logic [2:0] cnt;
    cnt = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (i < LOSS_WIN_MIN + int'(c)) cnt = cnt + {2'b00, h[i]};  // see R7
    end
    return cnt >= 3'(LOSS_ERRS);
  endfunction : win_loss

  t1fs_fmt_t         fmt;
  logic              is12;
  logic [6:0]        len;
  logic [4:0]        win;
  logic [7:0]        per;
  logic [HIST_W-1:0] pat;
  logic [HIST_W-1:0] mask;
  logic [2:0]        e;
  logic [6:0]        fidx;
  logic [6:0]        i12;
  logic [6:0]        fi;
  logic [7:0]        d;
  logic              err;
  logic              match;
  logic [HIST_W-1:0] hist_new;
  logic [FILL_W-1:0] fill_new;
  logic              ft_loss;
  logic              fs_loss;
  logic              lock_req;
  logic              new_search;
  logic              toggle;
  logic              acc;

  assign fmt  = s.ctl.framing_format_select;                         // see R3
  assign is12 = (fmt == FMT_F12) || (fmt == FMT_F72);

  always_comb begin
    len = MF_LEN_F4;
    win = HUNT_WIN_F4;
    per = PER_F4;                                                    // see R15
    case (fmt)
      FMT_F12: begin len = MF_LEN_F12; win = HUNT_WIN_F12; per = PER_F12; end
      FMT_ESF: begin len = MF_LEN_ESF; win = HUNT_WIN_ESF; per = PER_ESF; end
      FMT_F72: begin len = MF_LEN_F72; win = HUNT_WIN_F12; per = PER_F72; end
      default: begin len = MF_LEN_F4;  win = HUNT_WIN_F4;  per = PER_F4;  end
    endcase
  end

  // Hunt template: history bit i is the framing bit i frames before the last one
  always_comb begin
    pat  = '0;
    mask = '0;
    fi   = 7'h00;
    for (int i = 0; i < HIST_W; i++) begin
      if (fmt == FMT_F4) fi = 7'((3 - i) & 3);
      else fi = 7'(int'(len) - 1 - i);
      pat[i]  = exp_bit(fmt, fi)[0];
      mask[i] = (i < int'(win)) && (exp_bit(fmt, fi)[2:1] != 2'b00);  // see R18
    end
  end

  always_comb begin
    n          = s;
    mwe        = 1'b0;
    mwdata     = '0;
    e          = 3'h0;
    fidx       = 7'h00;
    i12        = 7'h00;
    d          = 8'h00;
    err        = 1'b0;
    match      = 1'b0;
    hist_new   = '0;
    fill_new   = '0;
    ft_loss    = 1'b0;
    fs_loss    = 1'b0;
    lock_req   = 1'b0;
    new_search = 1'b0;
    toggle     = 1'b0;
    acc        = wb_cyc_i && wb_stb_i && !s.ack;
    if (ce_i) begin
      // Wishbone slave, one wait state
      n.ack = acc;
      if (acc) begin
        n.dat = 32'h0;
        if (wb_adr_i == ADR_CTRL) begin
          n.dat = {24'h0, s.ctl};
          if (wb_we_i && wb_sel_i[0]) n.ctl = t1fs_ctl_t'(wb_dat_i[7:0]);
        end else if (wb_adr_i == ADR_STAT) begin
          n.dat = {26'h0, s.st, s.ralm, s.fsrf, s.lmfa, s.lfa};        // see R4
        end else if (wb_adr_i == ADR_FEC) begin
          n.dat = 32'(s.fec);
        end
      end

      // Line input stage
      n.s1_v = rx_bit_en_i;
      if (rx_bit_en_i) begin
        n.s1_bit  = rx_bit_i;
        n.s1_pos  = s.bit_pos;
        n.bit_pos = (s.bit_pos == LAST_BIT_POS) ? 8'h00 : s.bit_pos + 8'h01;  // see R2
      end

      if (s.st == ST_SEARCH && s.s1_v) begin
        if (s.wt) begin
          if (s.s1_pos == LAST_BIT_POS) begin
            n.wt = 1'b0;
            n.sf = 8'h00;
          end
        end else begin
          // First frame of a search overwrites stale history
          hist_new = (s.sf == 8'h00) ? HIST_W'(s.s1_bit) : {mrdata[HIST_W-2:0], s.s1_bit};
          fill_new = (s.sf == 8'h00) ? 5'h01 : mrdata[MEM_W-1:HIST_W];
          if (s.sf != 8'h00 && fill_new < 5'(HIST_W)) fill_new = fill_new + 5'h01;
          mwe    = 1'b1;
          mwdata = {fill_new, hist_new};
          match  = (fill_new >= win) && (((hist_new ^ pat) & mask) == '0);
          if (match) begin
            if (s.ncand == 2'h0 || s.s1_pos == s.cand_pos) begin
              n.cand_pos = s.s1_pos;
              n.cand_fr  = len - 7'h01;
              if (s.ncand == 2'h0) n.ncand = 2'h1;
            end else if (s.ncand == 2'h1) begin
              n.ncand = 2'h2;                                        // see R11
            end
          end else if (s.ncand != 2'h0 && s.s1_pos == s.cand_pos) begin
            n.cand_fr = (s.cand_fr == len - 7'h01) ? 7'h00 : s.cand_fr + 7'h01;
          end
          if (s.s1_pos == LAST_BIT_POS) begin
            n.sf = s.sf + 8'h01;
            if (s.sf == per - 8'h01) begin
              if (n.ncand == 2'h1) begin
                lock_req = 1'b1;                                     // see R11
              end else begin
                toggle  = (n.ncand == 2'h0);                         // see R14
                n.sf    = 8'h00;
                n.ncand = 2'h0;
              end
            end
          end
        end
      end

      if (s.st == ST_SYNC && s.s1_v) begin
        if (s.s1_pos == s.f_pos) begin
          fidx        = (s.frame_cnt == len - 7'h01) ? 7'h00 : s.frame_cnt + 7'h01;
          i12         = fidx % MF_LEN_F12;
          e           = exp_bit(fmt, fidx);
          n.frame_cnt = fidx;
          n.ra_b2     = s.b2_zero;                                   // see R17
          n.b2_zero   = 1'b1;
          err         = (e[2:1] != 2'b00) && (s.s1_bit != e[0]);
          if (e[2]) n.ft_h = {s.ft_h[4:0], err};
          if (e[1] && !s.mf_hunt) n.fs_h = {s.fs_h[4:0], err};
          if (err && !s.ctl.auto_resync_enable && !(e[1] && s.mf_hunt)) begin
            n.fec = s.fec + FEC_W'(1);                               // see R5 R6
          end
          if ((fmt == FMT_ESF && e[2]) || (is12 && e[1])) n.mf_err = s.mf_err | err;
          if (fmt == FMT_ESF && fidx == MF_LEN_ESF - 7'h01) begin
            n.bad_mf = n.mf_err ? s.bad_mf + 3'h1 : 3'h0;            // see R7
            n.mf_err = 1'b0;
          end
          if (is12 && e[1] && i12 == MF_LEN_F12 - 7'h01) begin
            n.ra_fs = s.s1_bit;                                      // see R20
            if (s.lmfa && !s.mf_hunt) begin
              n.mf_good = n.mf_err ? 2'h0 : s.mf_good + 2'h1;
              if (!n.mf_err && s.mf_good + 2'h1 == MF_GOOD_NEED) n.lmfa = 1'b0;  // see R21
            end
            n.mf_err = 1'b0;
          end
          // Split mode multiframe hunt on the multiframing bits only
          if (is12 && e[1] && s.mf_hunt) begin
            n.fs_sh = {s.fs_sh[4:0], s.s1_bit};
            if (n.fs_sh == F12_FS_HUNT) begin
              if (s.mf_seen && i12 == MF_LEN_F12 - 7'h01) begin
                n.mf_hunt = 1'b0;                                    // see R10
                n.lmfa    = 1'b0;
                n.mf_seen = 1'b0;
              end else begin
                n.mf_seen   = 1'b1;
                n.frame_cnt = MF_LEN_F12 - 7'h01;
              end
            end else if (i12 == MF_LEN_F12 - 7'h01) begin
              n.mf_seen = 1'b0;
            end
          end
          if (fmt == FMT_ESF && s.ctl.sync_loss_criterion == CRIT_ESF4) begin
            ft_loss = (n.bad_mf >= ESF_BAD_MF_MAX);                  // see R7
          end else begin
            ft_loss = win_loss(n.ft_h, s.ctl.sync_loss_criterion);
          end
          fs_loss = is12 && !s.mf_hunt && win_loss(n.fs_h, s.ctl.sync_loss_criterion);
          if (ft_loss || (fs_loss && !s.ctl.split_sync_select)) begin
            n.lfa  = 1'b1;                                           // see R22
            n.lmfa = 1'b1;                                           // see R21
            if (s.ctl.auto_resync_enable) new_search = 1'b1;         // see R8
            else n.st = ST_LOST;                                     // see R9
          end else if (fs_loss) begin
            n.lmfa    = 1'b1;                                        // see R10
            n.mf_hunt = 1'b1;
            n.mf_seen = 1'b0;
            n.fs_h    = 6'h00;
          end
        end else begin
          d = (s.s1_pos >= s.f_pos) ? s.s1_pos - s.f_pos : s.s1_pos + 8'(FRAME_BITS) - s.f_pos;
          if (3'(d - 8'h01) == ALARM_SLOT_BIT && s.s1_bit) n.b2_zero = 1'b0;  // see R17
        end
      end

      // Software resync requests, taken in a cycle with no line bit in flight
      if (!s.s1_v && s.st != ST_OFF && (s.frc_p || s.exl_p)) begin
        n.frc_p = 1'b0;
        n.exl_p = 1'b0;
        if (s.exl_p || s.st != ST_SEARCH) begin
          new_search = 1'b1;                                         // see R11 R12
        end else if (s.ncand != 2'h0) begin
          lock_req = 1'b1;                                           // see R12
        end else begin
          new_search = 1'b1;
          toggle     = 1'b1;                                         // see R14
        end
      end
      if (acc && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CMD) begin
        n.frc_p = n.frc_p | wb_dat_i[CMD_FRC];
        n.exl_p = n.exl_p | wb_dat_i[CMD_EXL];
      end

      if (lock_req) begin
        n.st        = ST_SYNC;
        n.lfa       = 1'b0;                                          // see R22
        n.lmfa      = is12;                                          // see R21
        n.f_pos     = n.cand_pos;
        n.frame_cnt = n.cand_fr;
        n.ft_h      = 6'h00;
        n.fs_h      = 6'h00;
        n.bad_mf    = 3'h0;
        n.mf_err    = 1'b0;
        n.mf_good   = 2'h0;
        n.mf_hunt   = 1'b0;
        n.mf_seen   = 1'b0;
        n.b2_zero   = 1'b1;
      end
      if (new_search) begin
        n.st    = ST_SEARCH;
        n.wt    = 1'b1;
        n.ncand = 2'h0;
        n.lfa   = 1'b1;
        n.lmfa  = 1'b1;
      end
      if (toggle) n.fsrf = ~s.fsrf;                                  // see R14

      if (!n.ctl.line_standard_select) begin
        n.st   = ST_OFF;                                             // see R1
        n.lfa  = 1'b1;
        n.lmfa = 1'b1;
      end else if (s.st == ST_OFF) begin
        n.st = ST_SEARCH;                                            // see R1
        n.wt = 1'b1;
      end

      if (fmt == FMT_F12 && s.ctl.alarm_method_select) n.ralm = n.ra_fs;   // see R20
      else if (fmt == FMT_F4 || fmt == FMT_F12) n.ralm = n.ra_b2;
      else n.ralm = 1'b0;
      if (n.st != ST_SYNC) n.ralm = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s         <= '0;
      s.ctl     <= t1fs_ctl_t'(CTRL_RST);
      s.st      <= ST_OFF;
      s.lfa     <= 1'b1;
      s.lmfa    <= 1'b1;
      s.b2_zero <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign wb_dat_o                    = s.dat;
  assign wb_ack_o                    = s.ack;
  assign frame_alignment_lost_o      = s.lfa;
  assign multiframe_alignment_lost_o = s.lmfa;

endmodule : t1fs_sync

// >>> testbench/t1fs_line_src.sv
// Purpose: Line side model sending F4 frames, one bit every 4 clocks
// Assumes: data bits all ones, so no data position imitates framing
// Notes: bad_i inverts every framing bit while high
`timescale 1ns/1ps
module t1fs_line_src (
  input  wire logic clk_i,
  input  wire logic bad_i,
  output logic      bit_o,
  output logic      en_o
);
  logic [1:0] div = 2'h0;
  logic [7:0] pos = 8'h00;
  logic [1:0] frm = 2'h0;
  initial bit_o = 1'b1;
  initial en_o = 1'b0;
  always @(posedge clk_i) begin
    div <= div + 2'h1;
    en_o <= (div == 2'h3);
    if (div == 2'h3) begin
      pos <= (pos == 8'hc0) ? 8'h00 : pos + 8'h01;
      if (pos == 8'hc0) frm <= frm + 2'h1;
      // Frame 1 framing bit 1, frame 3 and service bits 0
      bit_o <= (pos != 8'h00) ? 1'b1 : ((frm == 2'h0) ^ bad_i);
    end
  end
endmodule : t1fs_line_src

// >>> testbench/t1fs_sync_sva.sv
// Purpose: Port-level checks of the frame synchronizer
// Assumes: ce_i held high
// Notes: bound to every synchronizer instance
`timescale 1ns/1ps
module t1fs_sync_sva
  import t1fs_pkg::*;
(
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                ce_i,
  input wire logic                rx_bit_i,
  input wire logic                rx_bit_en_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [WB_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic                frame_alignment_lost_o,
  input wire logic                multiframe_alignment_lost_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("request not acknowledged");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_dat_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("read data moved without ack");
  a_unmapped_zero: assert property (wb_ack_o && $past(wb_adr_i > ADR_FEC
    || wb_adr_i == ADR_CMD) |-> wb_dat_o == 32'h0)
    else $error("unmapped or command read not zero");
  a_stat_lost: assert property (wb_ack_o && $past(wb_adr_i == ADR_STAT) |->
    wb_dat_o[0] == $past(frame_alignment_lost_o))
    else $error("status bit differs from lost output");
  a_sync_on_bit: assert property ($fell(frame_alignment_lost_o) |->
    $past(rx_bit_en_i, 2) || $past(rx_bit_en_i, 3) || $past(rx_bit_en_i, 4)
    || $past(wb_ack_o, 1) || $past(wb_ack_o, 2) || $past(wb_ack_o, 3))
    else $error("alignment regained without a line bit");
  a_lost_pair: assert property (frame_alignment_lost_o |-> multiframe_alignment_lost_o)
    else $error("frame lost without multiframe lost");
  c_sync: cover property ($fell(frame_alignment_lost_o));
  c_loss: cover property ($rose(frame_alignment_lost_o));
  c_read: cover property (wb_ack_o && !wb_we_i);
endmodule : t1fs_sync_sva
bind t1fs_sync t1fs_sync_sva t1fs_sync_sva_inst (.clk_i, .rst_i, .ce_i, .rx_bit_i,
  .rx_bit_en_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
  .wb_ack_o, .frame_alignment_lost_o, .multiframe_alignment_lost_o);

// >>> testbench/t1fs_sync_tb.sv
// Purpose: Self-checking bench for the frame synchronizer
// Assumes: F4 line traffic from the line model
// Notes: every wait is bounded
`timescale 1ns/1ps
module t1fs_sync_tb import t1fs_pkg::*;;
  logic        clk_i, rst_i, cyc, stb, we, bad, rx_bit, rx_en, ack, lfa, lmfa;
  logic [7:0]  adr;
  logic [31:0] dat, q, f0, rdat;
  int          mismatches, comparisons;
  t1fs_sync t1fs_sync_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .rx_bit_i(rx_bit),
    .rx_bit_en_i(rx_en), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .frame_alignment_lost_o(lfa), .multiframe_alignment_lost_o(lmfa));
  t1fs_line_src t1fs_line_src_inst (.clk_i(clk_i), .bad_i(bad), .bit_o(rx_bit), .en_o(rx_en));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1 && n < 9) begin
      @(posedge clk_i);
      n++;
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n == 9) chk(32'h0, 32'h1);
    @(posedge clk_i);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask : rd
  task automatic wait_lfa(input logic v);
    int n;
    n = 0;
    while (lfa !== v && n < 30000) begin
      @(posedge clk_i);
      n++;
    end
    chk(32'(lfa), 32'(v));
  endtask : wait_lfa
  task automatic inject();
    bad <= 1'b1;
    wait_lfa(1'b1);
    bad <= 1'b0;
  endtask : inject
  task automatic stop_test();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    mismatches++;
    stop_test();
  end
  initial begin
    {rst_i, cyc, stb, we, bad, adr, dat} = {1'b1, 44'h0};
    mismatches = 0;
    comparisons = 0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(ADR_CTRL, 32'hffffffff, 32'h0);
    rd(ADR_STAT, 32'hffffffff, 32'h3);
    rd(ADR_CMD, 32'hffffffff, 32'h0);
    rd(8'h10, 32'hffffffff, 32'h0);
    rd(ADR_FEC, 32'hffffffff, 32'h0);
    for (int i = 0; i < 16; i++) begin
      bus(1'b1, ADR_CTRL, 32'(i * 2));
      rd(ADR_CTRL, 32'hffffffff, 32'(i * 2));
    end
    bus(1'b1, ADR_CTRL, 32'h1);
    wait_lfa(1'b0);
    rd(ADR_STAT, 32'h31, 32'h30);
    chk(32'(lmfa), 32'h0);
    bus(1'b0, ADR_FEC, 32'h0);
    f0 = q;
    inject();
    repeat (12400) @(posedge clk_i);
    rd(ADR_STAT, 32'h31, 32'h11);
    bus(1'b0, ADR_FEC, 32'h0);
    chk(32'(q > f0), 32'h1);
    bus(1'b1, ADR_CMD, 32'h2);
    wait_lfa(1'b0);
    bus(1'b1, ADR_CTRL, 32'h21);
    bus(1'b0, ADR_FEC, 32'h0);
    f0 = q;
    inject();
    wait_lfa(1'b0);
    rd(ADR_FEC, 32'hffff, f0);
    stop_test();
  end
endmodule : t1fs_sync_tb
